// ==== hw/usp_pkg.sv ====
package usp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SR_W          = 41;
  localparam int IR_W          = 39;
  localparam int CS_W          = 34;
  localparam int PS_W          = 32;
  localparam int MSM_W         = 4;
  localparam int WD_W          = 29;
  localparam int WD_MSB_W      = 12;
  localparam int WD_LSB_W      = 17;
  localparam int SRC_W         = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SR_SEL_HI     = 40;
  localparam int SR_SEL_LO     = 39;
  localparam int IR_IMAGE_SEL  = 13;
  localparam int IR_OVERRIDE   = 12;
  localparam int CS_MSM_LSB    = 30;
  localparam int CS_WD_EN      = 29;
  localparam int PS_SRC_LSB    = 28;
  localparam int PS_MSM_LSB    = 22;
  localparam int SRC_EXT_CFG   = 3;
  localparam int SRC_CRC       = 2;
  localparam int SRC_STATUS    = 1;
  localparam int SRC_WATCHDOG  = 0;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [MSM_W-1:0] MSM_LOAD_IMG0        = 4'h2;
  localparam logic [MSM_W-1:0] MSM_LOAD_IMG1_REVERT = 4'h3;
  localparam logic [MSM_W-1:0] MSM_LOAD_IMG1        = 4'h4;
  localparam logic [MSM_W-1:0] MSM_LOAD_IMG0_REVERT = 4'h5;

  localparam logic [1:0] CAP_CURRENT = 2'h0;
  localparam logic [1:0] CAP_PREV1   = 2'h1;
  localparam logic [1:0] CAP_PREV2   = 2'h2;
  localparam logic [1:0] CAP_INPUT   = 2'h3;

  localparam logic [IR_W-1:0] IR_RESET = 39'h0;
  localparam logic [SR_W-1:0] SR_RESET = 41'h0;
  localparam logic [PS_W-1:0] PS_RESET = 32'h0;

  // Filter level is valid only on the fourth edge after reset: three
  // stages plus the agreeing level register, so the strap waits for it
  localparam logic [2:0] SETTLE_CYC  = 3'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [IR_W-1:0] usp_ir_t;

  typedef enum logic [1:0] {
    PH_SETTLE = 2'b01,
    PH_RUN    = 2'b10
  } usp_phase_t;

  typedef struct packed {
    logic upgrade_port_clock;
    logic shift_or_load_select;
    logic capture_or_update_select;
    logic upgrade_serial_in;
  } usp_port_pins_t;

  typedef struct packed {
    logic ext_reconfig_n;
    logic crc_error;
    logic ext_status_n;
    logic user_reconfig_request_n;
    logic watchdog_kick_n;
    logic config_sel_pin;
  } usp_src_pins_t;

  typedef struct packed {
    usp_phase_t         phase;
    logic [2:0]         settle;
    logic [SR_W-1:0]    sr;
    usp_ir_t            ir;
    logic               serial_out;
    logic [MSM_W-1:0]   msm;
    logic               image;
    logic [PS_W-1:0]    prev1;
    logic [PS_W-1:0]    prev2;
    logic [WD_W-1:0]    wd_cnt;
    logic               reconfig;
  } usp_state_t;

endpackage

// ==== hw/usp_sync.sv ====
`timescale 1ns/1ns
module usp_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } usp_sync_st_t;

  usp_sync_st_t st;
  usp_sync_st_t next_st;
  logic [W-1:0] agree;

  generate
    if (W < 1) begin : g_bad_w
      $error("usp_sync width must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Filter: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    agree       = ~(st.s2 ^ st.s3);
    next_st.s1  = din;
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    next_st.lvl = (st.s3 & agree) | (st.lvl & ~agree);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
  assign rise  = next_st.lvl & ~st.lvl;
  assign fall  = ~next_st.lvl & st.lvl;

endmodule

// ==== hw/usp_tick.sv ====
`timescale 1ns/1ns
module usp_tick #(
  parameter int DIV = 1
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } usp_tick_st_t;

  usp_tick_st_t st;
  usp_tick_st_t next_st;

  generate
    if (DIV < 1) begin : g_bad_div
      $error("usp_tick divider must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (st.cnt == LAST) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt  = st.cnt + CW'(1);
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

// ==== hw/usp_port.sv ====
`timescale 1ns/1ns
module usp_port
  import usp_pkg::*;
#(
  parameter int WD_TICK_DIV = 1
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire usp_pkg::usp_port_pins_t  port_pins,
  input  wire usp_pkg::usp_src_pins_t   src_pins,
  input  wire logic                     upgrade_enable,
  input  wire logic                     watchdog_enable,
  input  wire logic [WD_MSB_W-1:0]      watchdog_period_msb,
  output logic                          upgrade_serial_out,
  output logic                          image_select_bit,
  output logic                          image_select_override,
  output logic                          active_image,
  output logic [MSM_W-1:0]              msm_state,
  output logic                          watchdog_enabled_flag,
  output logic [WD_W-1:0]               watchdog_period_value,
  output logic                          reconfig_start
);

  import usp_pkg::*;

  generate
    if (WD_TICK_DIV < 1) begin : g_bad_div
      $error("usp_port watchdog divider must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin filters
  // ----------------------------------------------------------------
  usp_port_pins_t port_lvl;
  usp_port_pins_t port_rise;
  usp_src_pins_t  src_lvl;
  usp_src_pins_t  src_rise;
  usp_src_pins_t  src_fall;
  logic           wd_tick;

  usp_sync #(
    .W ($bits(usp_port_pins_t))
  ) u_port_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (port_pins),
    .level   (port_lvl),
    .rise    (port_rise),
    .fall    ()
  );

  usp_sync #(
    .W ($bits(usp_src_pins_t))
  ) u_src_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (src_pins),
    .level   (src_lvl),
    .rise    (src_rise),
    .fall    (src_fall)
  );

  usp_tick #(
    .DIV (WD_TICK_DIV)
  ) u_wd_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (wd_tick)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  usp_state_t       st;
  usp_state_t       next_st;

  logic             running;
  logic             port_edge;
  logic [WD_W-1:0]  wd_value;
  logic             wd_en;
  logic [WD_W-1:0]  wd_cnt_inc;
  logic             wd_expire;
  logic [CS_W-1:0]  cs_word;
  logic [SRC_W-1:0] src_flags;
  logic [SRC_W-1:0] src_win;
  logic             user_req;
  logic             src_error;
  logic             base_image;
  logic             new_image;
  logic [1:0]       cap_sel;

  // ----------------------------------------------------------------
  // Derived words
  // ----------------------------------------------------------------
  always_comb begin
    running    = (st.phase == PH_RUN);
    port_edge  = running && upgrade_enable && port_rise.upgrade_port_clock;
    wd_value   = {watchdog_period_msb, {WD_LSB_W{1'b0}}};
    wd_en      = running && watchdog_enable;
    wd_cnt_inc = st.wd_cnt + WD_W'(1);
    wd_expire  = wd_en && wd_tick && (wd_cnt_inc >= wd_value);
    cs_word    = {st.msm, wd_en, wd_value};
    cap_sel    = st.sr[SR_SEL_HI:SR_SEL_LO];
    src_flags  = '0;
    src_flags[SRC_EXT_CFG]  = src_fall.ext_reconfig_n;
    src_flags[SRC_CRC]      = src_rise.crc_error;
    src_flags[SRC_STATUS]   = src_fall.ext_status_n;
    src_flags[SRC_WATCHDOG] = wd_expire;
    user_req   = upgrade_enable && src_fall.user_reconfig_request_n;
  end

  // ----------------------------------------------------------------
  // Source priority: a higher bit overwrites every lower one
  // ----------------------------------------------------------------
  always_comb begin
    src_win = '0;
    for (int i = 0; i < SRC_W; i++) begin
      if (src_flags[i]) begin
        src_win    = '0;
        src_win[i] = 1'b1;
      end
    end
    src_error  = src_win[SRC_CRC] || src_win[SRC_WATCHDOG];
    base_image = st.ir[IR_OVERRIDE] ? st.ir[IR_IMAGE_SEL] : src_lvl.config_sel_pin;
    new_image  = src_error ? ~st.image : base_image;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.reconfig = 1'b0;

    case (st.phase)
      PH_SETTLE: begin
        // Strap is taken only once the pin filter has settled
        if (st.settle == SETTLE_CYC) begin
          next_st.phase = PH_RUN;
          next_st.image = src_lvl.config_sel_pin;
          next_st.msm   = src_lvl.config_sel_pin ? MSM_LOAD_IMG1 : MSM_LOAD_IMG0;
        end else begin
          next_st.settle = st.settle + 3'h1;
        end
      end
      PH_RUN: begin
        // Shift register port
        if (port_edge) begin
          if (port_lvl.shift_or_load_select) begin
            next_st.sr = {port_lvl.upgrade_serial_in, st.sr[SR_W-1:1]};
            next_st.serial_out = st.sr[1];
          end else if (port_lvl.capture_or_update_select) begin
            case (cap_sel)
              CAP_CURRENT: next_st.sr[IR_W-1:0] = usp_ir_t'(cs_word);
              CAP_PREV1:   next_st.sr[IR_W-1:0] = usp_ir_t'(st.prev1);
              CAP_PREV2:   next_st.sr[IR_W-1:0] = usp_ir_t'(st.prev2);
              CAP_INPUT:   next_st.sr[IR_W-1:0] = st.ir;
              default:     next_st.sr[IR_W-1:0] = st.sr[IR_W-1:0];
            endcase
            next_st.serial_out = next_st.sr[0];
          end else begin
            next_st.ir = st.sr[IR_W-1:0];
          end
        end

        // Watchdog count
        if (!wd_en || src_fall.watchdog_kick_n) begin
          next_st.wd_cnt = '0;
        end else if (wd_tick && !wd_expire) begin
          next_st.wd_cnt = wd_cnt_inc;
        end

        // Reconfiguration event
        if ((|src_flags) || user_req) begin
          next_st.reconfig = 1'b1;
          next_st.wd_cnt   = '0;
          next_st.prev2    = st.prev1;
          next_st.prev1    = PS_RESET;
          next_st.prev1[PS_SRC_LSB +: SRC_W] = src_win;
          next_st.prev1[PS_MSM_LSB +: MSM_W] = st.msm;
          next_st.image    = new_image;
          if (src_error) begin
            next_st.msm = new_image ? MSM_LOAD_IMG1_REVERT : MSM_LOAD_IMG0_REVERT;
          end else begin
            next_st.msm = new_image ? MSM_LOAD_IMG1 : MSM_LOAD_IMG0;
          end
        end
      end
      default: begin
        next_st.phase = PH_SETTLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st.phase      <= PH_SETTLE;
      st.settle     <= 3'h0;
      st.sr         <= SR_RESET;
      st.ir         <= IR_RESET;
      st.serial_out <= 1'b0;
      st.msm        <= MSM_LOAD_IMG0;
      st.image      <= 1'b0;
      st.prev1      <= PS_RESET;
      st.prev2      <= PS_RESET;
      st.wd_cnt     <= '0;
      st.reconfig   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign upgrade_serial_out    = st.serial_out;
  assign image_select_bit      = st.ir[IR_IMAGE_SEL];
  assign image_select_override = st.ir[IR_OVERRIDE];
  assign active_image          = st.image;
  assign msm_state             = st.msm;
  assign watchdog_enabled_flag = wd_en;
  assign watchdog_period_value = wd_value;
  assign reconfig_start        = st.reconfig;

endmodule

// ==== tb/usp_port_props.sv ====
`timescale 1ns/1ns
module usp_port_props
  import usp_pkg::*;
#(
  parameter int WD_TICK_DIV = 1
) (
  input wire logic                         sys_clk,
  input wire logic                         rst_n,
  input wire usp_pkg::usp_port_pins_t      port_pins,
  input wire usp_pkg::usp_src_pins_t       src_pins,
  input wire logic                         upgrade_enable,
  input wire logic                         watchdog_enable,
  input wire logic [usp_pkg::WD_MSB_W-1:0] watchdog_period_msb,
  input wire logic                         upgrade_serial_out,
  input wire logic                         image_select_bit,
  input wire logic                         image_select_override,
  input wire logic                         active_image,
  input wire logic [usp_pkg::MSM_W-1:0]    msm_state,
  input wire logic                         watchdog_enabled_flag,
  input wire logic [usp_pkg::WD_W-1:0]     watchdog_period_value,
  input wire logic                         reconfig_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // Pins pass a filter, so effects land three to five cycles late
  // ------------------------------------------------------------
  wire upd_mode = !port_pins.shift_or_load_select && !port_pins.capture_or_update_select;
  sequence s_start_soon;
    ##[1:8] reconfig_start;
  endsequence
  property p_period; watchdog_period_value == {watchdog_period_msb, 17'h0}; endproperty
  a_period: assert property (p_period) else $error("bad period value");
  property p_wd_flag; watchdog_enabled_flag |-> watchdog_enable; endproperty
  a_wd_flag: assert property (p_wd_flag) else $error("flag without enable");
  property p_img; (msm_state inside {4'h3, 4'h4}) == active_image; endproperty
  a_img: assert property (p_img) else $error("state code and image disagree");
  property p_upd;
    $changed({image_select_bit, image_select_override}) |-> $past(upd_mode, 4);
  endproperty
  a_upd: assert property (p_upd) else $error("input register moved outside update");
  property p_out; $changed(upgrade_serial_out) |-> !$past(upd_mode, 4); endproperty
  a_out: assert property (p_out) else $error("serial out moved in update");
  property p_out_clk;
    $changed(upgrade_serial_out) |-> $past(port_pins.upgrade_port_clock, 3);
  endproperty
  a_out_clk: assert property (p_out_clk) else $error("serial out moved without clock");
  property p_req;
    $fell(src_pins.user_reconfig_request_n) && upgrade_enable |-> s_start_soon;
  endproperty
  a_req: assert property (p_req) else $error("user request not taken");
  property p_ext; $fell(src_pins.ext_reconfig_n) |-> s_start_soon; endproperty
  a_ext: assert property (p_ext) else $error("external request not taken");
  property p_ovr;
    (reconfig_start && image_select_override && (msm_state inside {4'h2, 4'h4}))
      |-> active_image == image_select_bit;
  endproperty
  a_ovr: assert property (p_ovr) else $error("override image not used");
  property p_pin;
    (reconfig_start && !image_select_override && (msm_state inside {4'h2, 4'h4}))
      |-> active_image == src_pins.config_sel_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("pin image not used");
endmodule

bind usp_port usp_port_props #(.WD_TICK_DIV(WD_TICK_DIV)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .port_pins(port_pins), .src_pins(src_pins),
  .upgrade_enable(upgrade_enable), .watchdog_enable(watchdog_enable),
  .watchdog_period_msb(watchdog_period_msb), .upgrade_serial_out(upgrade_serial_out),
  .image_select_bit(image_select_bit), .image_select_override(image_select_override),
  .active_image(active_image), .msm_state(msm_state),
  .watchdog_enabled_flag(watchdog_enabled_flag),
  .watchdog_period_value(watchdog_period_value), .reconfig_start(reconfig_start));

// ==== tb/usp_user_model.sv ====
`timescale 1ns/1ns
module usp_user_model
  import usp_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               upgrade_serial_out,
  output usp_pkg::usp_port_pins_t port_pins,
  output logic                    user_req_n,
  output logic                    kick_n
);
  initial begin
    port_pins = '0;
    user_req_n = 1'b1;
    kick_n = 1'b1;
  end
  // ------------------------------------------------------------
  // One port clock of 8 cycles; levels held 4 cycles around the rise
  // ------------------------------------------------------------
  task automatic bit_cycle(input logic sl, input logic cu, input logic din, output logic dout);
    port_pins.shift_or_load_select = sl;
    port_pins.capture_or_update_select = cu;
    port_pins.upgrade_serial_in = din;
    repeat (4) @(negedge sys_clk);
    dout = upgrade_serial_out;
    port_pins.upgrade_port_clock = 1'b1;
    repeat (4) @(negedge sys_clk);
    port_pins.upgrade_port_clock = 1'b0;
  endtask
  task automatic xfer(input logic [SR_W-1:0] wd, output logic [SR_W-1:0] rd);
    for (int i = 0; i < SR_W; i++) begin
      bit_cycle(1'b1, 1'b0, wd[i], rd[i]);
    end
  endtask
  // Data is unused here, so show the inverse rather than a stale bit
  task automatic op(input logic cu);
    logic d;
    bit_cycle(1'b0, cu, ~port_pins.upgrade_serial_in, d);
  endtask
  task automatic request();
    user_req_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    user_req_n = 1'b1;
  endtask
  task automatic kick();
    kick_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    kick_n = 1'b1;
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import usp_pkg::*;
  logic                sys_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                upgrade_enable = 1'b1;
  logic                watchdog_enable = 1'b0;
  logic [WD_MSB_W-1:0] wd_msb = 12'h5a3;
  logic                ext_n = 1'b1;
  logic                crc = 1'b0;
  logic                stat_n = 1'b1;
  logic                cfg_pin = 1'b0;
  logic                user_req_n, kick_n, serial_out, sel_bit, sel_ovr, act_img, wd_flag, start;
  usp_port_pins_t      port_pins;
  usp_src_pins_t       src_pins;
  logic [MSM_W-1:0]    msm;
  logic [WD_W-1:0]     period;
  logic [SR_W-1:0]     rd;
  int                  n_errors = 0;
  int                  checks_done = 0;
  int                  n_starts = 0;

  assign src_pins = {ext_n, crc, stat_n, user_req_n, kick_n, cfg_pin};
  usp_port #(.WD_TICK_DIV(1)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .port_pins(port_pins), .src_pins(src_pins),
    .upgrade_enable(upgrade_enable), .watchdog_enable(watchdog_enable),
    .watchdog_period_msb(wd_msb), .upgrade_serial_out(serial_out),
    .image_select_bit(sel_bit), .image_select_override(sel_ovr), .active_image(act_img),
    .msm_state(msm), .watchdog_enabled_flag(wd_flag), .watchdog_period_value(period),
    .reconfig_start(start));
  usp_user_model user_side (.sys_clk(sys_clk), .upgrade_serial_out(serial_out),
    .port_pins(port_pins), .user_req_n(user_req_n), .kick_n(kick_n));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // Counted mid-cycle so the one-cycle pulse is read where it is settled
  always @(negedge sys_clk) if (start === 1'b1) n_starts++;

  task automatic check(input logic [SR_W-1:0] seen, input logic [SR_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic test_done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic cap(input logic [1:0] sel);
    user_side.xfer({sel, 39'h0}, rd);
    user_side.op(1'b1);
    user_side.xfer('0, rd);
  endtask
  function automatic logic [IR_W-1:0] prev(input logic [3:0] src, input logic [3:0] st);
    return {7'h0, src, 2'b00, st, 22'h0};
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    wait_n(5);
    rst_n = 1'b1;
    wait_n(12);
    check(msm, MSM_LOAD_IMG0);
    check(period, {wd_msb, 17'h0});
    user_side.request();
    wait_n(12);
    check(n_starts, 1);
    check(act_img, cfg_pin);
    test_done("reset and pin image");
    user_side.xfer({2'b00, 39'h3000}, rd);
    check(sel_bit, 1'b0);
    upgrade_enable = 1'b0;
    user_side.op(1'b0);
    wait_n(4);
    upgrade_enable = 1'b1;
    check(sel_ovr, 1'b0);
    user_side.op(1'b0);
    wait_n(4);
    check({sel_bit, sel_ovr}, 2'b11);
    cap(CAP_INPUT);
    check(rd, {CAP_INPUT, 39'h3000});
    check(sel_bit, 1'b1);
    test_done("update and readback");
    watchdog_enable = 1'b1;
    user_side.kick();
    cap(CAP_CURRENT);
    check(rd[38:0], {5'h0, MSM_LOAD_IMG0, 1'b1, wd_msb, 17'h0});
    check(wd_flag, 1'b1);
    watchdog_enable = 1'b0;
    test_done("current state");
    user_side.request();
    wait_n(12);
    check(msm, MSM_LOAD_IMG1);
    cap(CAP_PREV1);
    check(rd[38:0], prev(4'b0000, MSM_LOAD_IMG0));
    ext_n = 1'b0;
    crc = 1'b1;
    wait_n(12);
    ext_n = 1'b1;
    crc = 1'b0;
    wait_n(12);
    check(n_starts, 3);
    cap(CAP_PREV1);
    check(rd[38:0], prev(4'b1000, MSM_LOAD_IMG1));
    cap(CAP_PREV2);
    check(rd[38:0], prev(4'b0000, MSM_LOAD_IMG0));
    test_done("tied sources");
    crc = 1'b1;
    wait_n(12);
    crc = 1'b0;
    wait_n(12);
    check(msm, MSM_LOAD_IMG0_REVERT);
    stat_n = 1'b0;
    wait_n(12);
    stat_n = 1'b1;
    wait_n(12);
    check(msm, MSM_LOAD_IMG1);
    cap(CAP_PREV1);
    check(rd[38:0], prev(4'b0010, MSM_LOAD_IMG0_REVERT));
    wd_msb = 12'h000;
    watchdog_enable = 1'b1;
    wait_n(10);
    watchdog_enable = 1'b0;
    wait_n(12);
    check(n_starts > 5, 1'b1);
    cap(CAP_PREV1);
    check(rd[31:28], 4'b0001);
    test_done("revert and watchdog");
    cfg_pin = 1'b1;
    rst_n = 1'b0;
    wait_n(5);
    rst_n = 1'b1;
    wait_n(12);
    check(act_img, 1'b1);
    check(msm, MSM_LOAD_IMG1);
    check({sel_bit, sel_ovr}, 2'b00);
    user_side.request();
    wait_n(12);
    check(act_img, 1'b1);
    check(msm, MSM_LOAD_IMG1);
    test_done("reset with pin image one");
    report_and_stop();
  end

  // Tests need about 5200 cycles; over five times that means a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end
endmodule
